/* design/i2c_fifo_level_abort_status.sv */
// Purpose: FIFO levels, data hold time and transmit abort causes
// Assumes: Controller core feeds events and config synchronous to ref_clk
// Notes: APB slave, answers in the second access cycle
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module i2c_fifo_level_abort_status
	import i2c_status_pkg::*;
#(
	parameter int TX_DEPTH = 32,
	parameter int RX_DEPTH = 32
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire i2c_status_pkg::ctrl_cfg_t cfg,
	input wire i2c_status_pkg::ctrl_events_t ev,
	output logic [i2c_status_pkg::HOLD_W-1:0] dataHoldCycles,
	output logic txFlush,
	output logic busLost,
	output logic irq
);
	import i2c_status_pkg::*;

	localparam logic [LEVEL_W-1:0] TX_FULL = LEVEL_W'(TX_DEPTH);
	localparam logic [LEVEL_W-1:0] RX_FULL = LEVEL_W'(RX_DEPTH);

	status_state_t st;
	status_state_t next_st;

	logic access;
	logic wrDone;
	logic mapped;
	logic sdaMismatch;
	logic slvLost;
	logic mstLost;
	logic flushTx;
	logic sbyteCause;
	logic abortClear;
	logic [15:0] abortSet;
	logic [31:0] readMux;
	logic [15:0] busStatus;

	// ----------------------------------------------------------------
	// Event decode
	// ----------------------------------------------------------------
	always_comb
	begin
		// Both roles are checked independently, so either can lose
		sdaMismatch = ev.sclRise && (ev.sdaIn != ev.sdaIntended);
		slvLost = ev.slvTxActive && sdaMismatch;
		mstLost = ev.mstTxActive && sdaMismatch;
		flushTx = ev.slvReadCmdRecv && (st.txLevel != LEVEL_RST);
		// Level cause: stays present until software fixes the setup
		sbyteCause = !cfg.restartAllow && cfg.commandSelA
			&& cfg.generalCallOrStartbyteSel;
		abortSet = ABORT_RST;
		abortSet[AB_SLV_RD_CMD] = ev.slvReadServing && ev.dataCmdWrite
			&& ev.dataCmdRead;
		abortSet[AB_SLV_BUS_LOST] = slvLost;
		abortSet[AB_SLV_FLUSH] = flushTx;
		abortSet[AB_ARBITRATION_LOST_ABORT] = slvLost || mstLost;
		abortSet[AB_MST_DIS] = ev.mstStartReq && !cfg.masterEnable;
		abortSet[AB_10B_RD] = ev.mstStartReq && !cfg.restartAllow
			&& cfg.tenBitAddr && ev.mstReadReq;
		abortSet[AB_SBYTE_NORST] = sbyteCause;
		abortSet[AB_HS_NORST] = ev.mstStartReq && !cfg.restartAllow
			&& cfg.highSpeed;
		abortSet[AB_SBYTE_ACK] = ev.startByteAcked;
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	always_comb
	begin
		access = psel && penable;
		wrDone = access && pwrite && st.pready;
		busStatus = 16'h0000;
		busStatus[0] = ev.mstActive || ev.slvActive;
		busStatus[1] = st.txLevel != TX_FULL;
		busStatus[2] = st.txLevel == LEVEL_RST;
		busStatus[3] = st.rxLevel != LEVEL_RST;
		busStatus[4] = st.rxLevel == RX_FULL;
		busStatus[5] = ev.mstActive;
		busStatus[6] = ev.slvActive;
		mapped = 1'b1;
		readMux = 32'h0000_0000;
		case (paddr)
			BUS_STATUS_ADDR: readMux = {16'h0000, busStatus};
			TX_FIFO_LEVEL_ADDR: readMux = 32'(st.txLevel);
			RX_FIFO_LEVEL_ADDR: readMux = 32'(st.rxLevel);
			DATA_HOLD_TIME_ADDR: readMux = 32'(st.holdTime);
			TX_ABORT_CAUSE_ADDR: readMux = 32'(st.abortCause);
			IRQ_STATUS_ADDR: readMux = 32'(st.irqStatus);
			IRQ_MASK_ADDR: readMux = 32'(st.irqMask);
			default: mapped = 1'b0;
		endcase
		// Clearing the abort interrupt also clears the cause bits
		abortClear = wrDone && (paddr == IRQ_STATUS_ADDR)
			&& pwdata[IRQ_TX_ABORT];
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		// Answer in the second access cycle, then drop
		next_st.pready = access && !st.pready;
		next_st.prdata = (access && !st.pready && !pwrite) ? readMux
			: 32'h0000_0000;
		next_st.pslverr = access && !st.pready && !mapped;
		if (wrDone && paddr == DATA_HOLD_TIME_ADDR)
			next_st.holdTime = pwdata[HOLD_W-1:0];
		if (wrDone && paddr == IRQ_MASK_ADDR)
			next_st.irqMask = pwdata[IRQ_W-1:0];

		// Fifo levels; push refused when full, pop when empty
		if (ev.txPush && st.txLevel != TX_FULL && !(ev.txPop
			&& st.txLevel != LEVEL_RST))
			next_st.txLevel = st.txLevel + 6'h01;
		else if (ev.txPop && st.txLevel != LEVEL_RST && !(ev.txPush
			&& st.txLevel != TX_FULL))
			next_st.txLevel = st.txLevel - 6'h01;
		if (ev.rxPush && st.rxLevel != RX_FULL && !(ev.rxPop
			&& st.rxLevel != LEVEL_RST))
			next_st.rxLevel = st.rxLevel + 6'h01;
		else if (ev.rxPop && st.rxLevel != LEVEL_RST && !(ev.rxPush
			&& st.rxLevel != RX_FULL))
			next_st.rxLevel = st.rxLevel - 6'h01;
		if (flushTx || !cfg.ctrlEnable)
			next_st.txLevel = LEVEL_RST;
		if (!cfg.ctrlEnable)
			next_st.rxLevel = LEVEL_RST;

		// Sticky causes; set wins over clear except bit 9
		next_st.abortCause = (abortClear ? ABORT_RST : st.abortCause)
			| abortSet;
		if (abortClear)
			next_st.abortCause[AB_SBYTE_NORST] = 1'b0;

		// Interrupt status: sticky, write one to clear, set wins
		next_st.irqStatus = st.irqStatus;
		if (wrDone && paddr == IRQ_STATUS_ADDR)
			next_st.irqStatus = st.irqStatus & ~pwdata[IRQ_W-1:0];
		if (abortSet != ABORT_RST)
			next_st.irqStatus[IRQ_TX_ABORT] = 1'b1;
		if (slvLost || mstLost)
			next_st.irqStatus[IRQ_BUS_LOST] = 1'b1;
		next_st.irq = |(next_st.irqStatus & next_st.irqMask);
		next_st.txFlush = flushTx || !cfg.ctrlEnable;
		next_st.busLost = slvLost || mstLost;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st.txLevel <= LEVEL_RST;
			st.rxLevel <= LEVEL_RST;
			st.holdTime <= HOLD_RST;
			st.abortCause <= ABORT_RST;
			st.irqStatus <= IRQ_RST;
			st.irqMask <= IRQ_RST;
			st.prdata <= 32'h0000_0000;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
			st.irq <= 1'b0;
			st.txFlush <= 1'b0;
			st.busLost <= 1'b0;
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign dataHoldCycles = st.holdTime;
	assign txFlush = st.txFlush;
	assign busLost = st.busLost;
	assign irq = st.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_tx_level_bound: assert property (st.txLevel <= TX_FULL)
		else $error("tx level above depth");
	a_rx_disable_flush: assert property (!cfg.ctrlEnable |=>
		st.rxLevel == LEVEL_RST && st.txLevel == LEVEL_RST)
		else $error("levels not flushed on disable");
	a_hold_write: assert property (wrDone && paddr == DATA_HOLD_TIME_ADDR
		|=> st.holdTime == $past(pwdata[HOLD_W-1:0]))
		else $error("hold time not written");
	a_slave_rd_cmd: assert property (ev.slvReadServing && ev.dataCmdWrite
		&& ev.dataCmdRead |=> st.abortCause[AB_SLV_RD_CMD])
		else $error("bit 15 not set");
	a_slave_lost_pair: assert property (st.abortCause[AB_SLV_BUS_LOST]
		&& !$past(st.abortCause[AB_SLV_BUS_LOST])
		|-> st.abortCause[AB_ARBITRATION_LOST_ABORT])
		else $error("bit 12 missing with bit 14");
	a_mismatch_lost: assert property (ev.mstTxActive && ev.sclRise
		&& ev.sdaIn != ev.sdaIntended |=> busLost
		&& st.abortCause[AB_ARBITRATION_LOST_ABORT])
		else $error("mismatch not flagged");
	a_flush_abort: assert property (ev.slvReadCmdRecv
		&& st.txLevel != LEVEL_RST |=> st.txLevel == LEVEL_RST
		&& st.abortCause[AB_SLV_FLUSH]
		&& st.irqStatus[IRQ_TX_ABORT])
		else $error("slave flush abort missing");
	a_master_dis: assert property (ev.mstStartReq && !cfg.masterEnable
		|=> st.abortCause[AB_MST_DIS])
		else $error("bit 11 not set");
	a_sbyte_reassert: assert property (abortClear && sbyteCause
		|=> !st.abortCause[AB_SBYTE_NORST] ##1
		(st.abortCause[AB_SBYTE_NORST] || !$past(sbyteCause)))
		else $error("bit 9 not re-asserted");
	a_cause_sticky: assert property (st.abortCause[AB_SBYTE_ACK]
		&& !abortClear |=> st.abortCause[AB_SBYTE_ACK])
		else $error("cause bit lost without clear");
	a_apb_answer: assert property (access && !pready |=> pready ##1
		!pready)
		else $error("apb answer timing");

	// ----------------------------------------------------------------
	// Bus answer checks
	// ----------------------------------------------------------------
	// Error and data only ever travel with the ready pulse

	a_err_with_ready: assert property (pslverr
		|-> pready)
		else $error("error without ready");

	a_read_idle_zero: assert property (!pready
		|-> prdata == 32'h0000_0000)
		else $error("read data outside answer");

	a_hold_stable: assert property (!(wrDone
		&& paddr == DATA_HOLD_TIME_ADDR) |=> $stable(st.holdTime))
		else $error("hold time changed without write");

	// ----------------------------------------------------------------
	// Level checks
	// ----------------------------------------------------------------
	// Pushes and pops move the count by one only when not blocked

	a_rx_level_bound: assert property (st.rxLevel <= RX_FULL)
		else $error("rx level above depth");

	a_tx_push_count: assert property (ev.txPush && !ev.txPop
		&& st.txLevel != TX_FULL && cfg.ctrlEnable && !flushTx
		|=> st.txLevel == $past(st.txLevel) + 6'h01)
		else $error("tx push not counted");

	a_rx_push_count: assert property (ev.rxPush && !ev.rxPop
		&& st.rxLevel != RX_FULL && cfg.ctrlEnable
		|=> st.rxLevel == $past(st.rxLevel) + 6'h01)
		else $error("rx push not counted");

	a_rx_pop_count: assert property (ev.rxPop && !ev.rxPush
		&& st.rxLevel != LEVEL_RST && cfg.ctrlEnable
		|=> st.rxLevel == $past(st.rxLevel) - 6'h01)
		else $error("rx pop not counted");

	a_flush_level: assert property (!cfg.ctrlEnable
		|=> txFlush)
		else $error("flush not shown while disabled");

	// ----------------------------------------------------------------
	// Abort cause checks
	// ----------------------------------------------------------------
	// Each cause is checked from its own inputs; only the clear check uses abortSet

	a_slave_lost_bits: assert property (ev.slvTxActive
		&& sdaMismatch |=> st.abortCause[AB_SLV_BUS_LOST]
		&& st.abortCause[AB_ARBITRATION_LOST_ABORT])
		else $error("slave loss bits missing");

	a_both_roles_lost: assert property (slvLost && mstLost
		|=> busLost && st.abortCause[AB_SLV_BUS_LOST]
		&& st.abortCause[AB_ARBITRATION_LOST_ABORT])
		else $error("dual role loss not flagged");

	a_master_arbitration_lost_abort: assert property (mstLost
		|=> st.abortCause[AB_ARBITRATION_LOST_ABORT])
		else $error("bit 12 not set");

	a_ten_bit_read: assert property (ev.mstStartReq
		&& !cfg.restartAllow && cfg.tenBitAddr && ev.mstReadReq
		|=> st.abortCause[AB_10B_RD])
		else $error("bit 10 not set");

	a_sbyte_set: assert property (sbyteCause && !abortClear
		|=> st.abortCause[AB_SBYTE_NORST])
		else $error("bit 9 not set");

	a_sbyte_cleared: assert property (abortClear && !sbyteCause
		|=> !st.abortCause[AB_SBYTE_NORST])
		else $error("bit 9 not cleared");

	a_highspeed_norst: assert property (ev.mstStartReq
		&& !cfg.restartAllow && cfg.highSpeed
		|=> st.abortCause[AB_HS_NORST])
		else $error("bit 8 not set");

	a_sbyte_acked: assert property (ev.startByteAcked
		|=> st.abortCause[AB_SBYTE_ACK])
		else $error("bit 7 not set");

	a_cause_cleared: assert property (abortClear
		&& abortSet == ABORT_RST |=> st.abortCause == ABORT_RST)
		else $error("causes not cleared");

	// ----------------------------------------------------------------
	// Interrupt checks
	// ----------------------------------------------------------------
	// Status set wins over a clear in the same cycle

	a_abort_irq: assert property (abortSet != ABORT_RST
		|=> st.irqStatus[IRQ_TX_ABORT])
		else $error("abort status not set");

	a_lost_irq: assert property (slvLost || mstLost
		|=> st.irqStatus[IRQ_BUS_LOST])
		else $error("bus lost status not set");

	a_irq_level: assert property (irq
		== |(st.irqStatus & st.irqMask))
		else $error("irq level wrong");
endmodule
`default_nettype wire

/* design/i2c_status_pkg.sv */
// Purpose: Constants and carriers for the I2C level/abort status block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Printed offsets are byte addresses
package i2c_status_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [31:0] BUS_STATUS_ADDR = 32'h5000_1370;
	localparam logic [31:0] TX_FIFO_LEVEL_ADDR = 32'h5000_1374;
	localparam logic [31:0] RX_FIFO_LEVEL_ADDR = 32'h5000_1378;
	localparam logic [31:0] DATA_HOLD_TIME_ADDR = 32'h5000_137C;
	localparam logic [31:0] TX_ABORT_CAUSE_ADDR = 32'h5000_1380;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000_13A0;
	localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_13A4;
	// ----------------------------------------------------------------
	// Reset values and field layout
	// ----------------------------------------------------------------
	localparam int LEVEL_W = 6;
	localparam int HOLD_W = 16;
	localparam int IRQ_W = 2;
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 6'h00;
	localparam logic [HOLD_W-1:0] HOLD_RST = 16'h0001;
	localparam logic [15:0] ABORT_RST = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
	localparam int AB_SLV_RD_CMD = 15;
	localparam int AB_SLV_BUS_LOST = 14;
	localparam int AB_SLV_FLUSH = 13;
	localparam int AB_ARBITRATION_LOST_ABORT = 12;
	localparam int AB_MST_DIS = 11;
	localparam int AB_10B_RD = 10;
	localparam int AB_SBYTE_NORST = 9;
	localparam int AB_HS_NORST = 8;
	localparam int AB_SBYTE_ACK = 7;
	localparam int IRQ_TX_ABORT = 0;
	localparam int IRQ_BUS_LOST = 1;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ctrlEnable;
		logic masterEnable;
		logic restartAllow;
		logic commandSelA;
		logic generalCallOrStartbyteSel;
		logic tenBitAddr;
		logic highSpeed;
	} ctrl_cfg_t;
	typedef struct packed {
		logic slvReadServing;
		logic dataCmdWrite;
		logic dataCmdRead;
		logic slvTxActive;
		logic mstTxActive;
		logic sclRise;
		logic sdaIn;
		logic sdaIntended;
		logic slvReadCmdRecv;
		logic mstStartReq;
		logic mstReadReq;
		logic startByteAcked;
		logic txPush;
		logic txPop;
		logic rxPush;
		logic rxPop;
		logic mstActive;
		logic slvActive;
	} ctrl_events_t;
	typedef struct packed {
		logic [LEVEL_W-1:0] txLevel;
		logic [LEVEL_W-1:0] rxLevel;
		logic [HOLD_W-1:0] holdTime;
		logic [15:0] abortCause;
		logic [IRQ_W-1:0] irqStatus;
		logic [IRQ_W-1:0] irqMask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic txFlush;
		logic busLost;
	} status_state_t;
endpackage

/* tb/i2c_bus_peer.sv */
// Purpose: Remote bus party seen by the status block
// Assumes: One clock line rise every four ref_clk cycles
// Notes: A clash makes the sampled data differ from the driven bit
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_peer
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clash,
	output logic sclRise,
	output logic sdaIn,
	output logic sdaIntended
);
	logic [1:0] phase;
	logic bitVal;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			phase <= 2'h0;
			bitVal <= 1'b0;
		end
		else
		begin
			phase <= phase + 2'h1;
			if (phase == 2'h3)
				bitVal <= ~bitVal;
		end
	end
	assign sclRise = (phase == 2'h3);
	assign sdaIntended = bitVal;
	// Peer pulls the line the other way while clashing
	assign sdaIn = bitVal ^ clash;
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the level and abort status block
// Assumes: APB answer and event timing as the design hands over
// Notes: Reads queue their expectation; a monitor compares
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import i2c_status_pkg::*;
	localparam ctrl_cfg_t GOOD = 7'h70;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
	logic [31:0] paddr, pwdata, prdata;
	logic [HOLD_W-1:0] hold;
	logic clash, sclRise, sdaIn, sdaIntended, flush;
	ctrl_cfg_t cfg;
	ctrl_events_t evDrv, evBus;
	int failures, checks, cycles;
	logic [32:0] q[$];
	logic [32:0] nt;
	always_comb
	begin
		evBus = evDrv;
		evBus.sclRise = sclRise;
		evBus.sdaIn = sdaIn;
		evBus.sdaIntended = sdaIntended;
	end
	i2c_fifo_level_abort_status dut (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cfg(cfg), .ev(evBus), .dataHoldCycles(hold),
		.txFlush(flush), .busLost(), .irq(irq));
	i2c_bus_peer peer (.ref_clk(ref_clk), .rst(rst), .clash(clash),
		.sclRise(sclRise), .sdaIn(sdaIn), .sdaIntended(sdaIntended));
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// ----
	// Read monitor
	// ----
	always @(posedge ref_clk)
		if (psel && penable && pready && !pwrite)
		begin
			nt = q.pop_front();
			checks++;
			if ({pslverr, prdata} !== nt)
			begin
				failures++;
				$display("wrong value read %h expected %h seen %h", paddr,
					nt, {pslverr, prdata});
			end
		end
	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Let the registered irq settle before any check
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [31:0] a, x, input logic e);
		q.push_back({e, x});
		xfer(1'b0, a, 32'h0000_0000);
	endtask
	task automatic pulse(input ctrl_events_t e, input int n);
		@(posedge ref_clk);
		evDrv <= e;
		clash <= (n > 1);
		repeat (n) @(posedge ref_clk);
		evDrv <= '0;
		clash <= 1'b0;
	endtask
	task automatic cause(input int i);
		ctrl_cfg_t c;
		ctrl_events_t e;
		logic [15:0] x;
		int n;
		c = GOOD;
		e = '0;
		n = 1;
		case (i)
		0: begin e.slvReadServing = 1; e.dataCmdWrite = 1; e.dataCmdRead = 1; x = 16'h8000; end
		1: begin e.slvTxActive = 1; e.mstActive = 1; e.slvActive = 1; n = 6; x = 16'h5000; end
		2: begin e.slvReadCmdRecv = 1; x = 16'h2000; end
		3: begin e.mstTxActive = 1; n = 6; x = 16'h1000; end
		4: begin c.masterEnable = 0; e.mstStartReq = 1; x = 16'h0800; end
		5: begin c.restartAllow = 0; c.tenBitAddr = 1; e.mstStartReq = 1; e.mstReadReq = 1; x = 16'h0400; end
		6: begin c.restartAllow = 0; c.commandSelA = 1; c.generalCallOrStartbyteSel = 1; x = 16'h0200; end
		7: begin c.restartAllow = 0; c.highSpeed = 1; e.mstStartReq = 1; x = 16'h0100; end
		default: begin e.startByteAcked = 1; x = 16'h0080; end
		endcase
		cfg <= c;
		pulse(e, n);
		rd(TX_ABORT_CAUSE_ADDR, {16'h0000, x}, 1'b0);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		if (i == 2)
			rd(TX_FIFO_LEVEL_ADDR, 32'h0000_0000, 1'b0);
		if (i == 6)
		begin
			xfer(1'b1, IRQ_STATUS_ADDR, 32'h0000_0001);
			rd(TX_ABORT_CAUSE_ADDR, 32'h0000_0200, 1'b0);
		end
		cfg <= GOOD;
		xfer(1'b1, IRQ_STATUS_ADDR, 32'h0000_0001);
		rd(TX_ABORT_CAUSE_ADDR, 32'h0000_0000, 1'b0);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		$display("test cause %0d done", i);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			final_report();
		end
	end
	initial
	begin
		ctrl_events_t e;
		int k, m;
		logic [31:0] h;
		{psel, penable, pwrite, clash, rst} = 5'b0_0001;
		{paddr, pwdata, failures, checks, cycles} = '0;
		cfg = GOOD;
		evDrv = '0;
		e = '0;
		void'($urandom(91));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(BUS_STATUS_ADDR, 32'h0000_0006, 1'b0);
		rd(TX_FIFO_LEVEL_ADDR, 32'h0000_0000, 1'b0);
		rd(RX_FIFO_LEVEL_ADDR, 32'h0000_0000, 1'b0);
		rd(DATA_HOLD_TIME_ADDR, 32'h0000_0001, 1'b0);
		rd(IRQ_MASK_ADDR, 32'h0000_0000, 1'b0);
		rd(32'h5000_1384, 32'h0000_0000, 1'b1);
		h = $urandom;
		xfer(1'b1, DATA_HOLD_TIME_ADDR, h);
		rd(DATA_HOLD_TIME_ADDR, {16'h0000, h[15:0]}, 1'b0);
		chk("hold", {16'h0000, h[15:0]}, {16'h0000, hold});
		$display("test registers done");
		k = $urandom_range(1, 6);
		m = $urandom_range(2, 6);
		e.txPush = 1'b1;
		repeat (k) pulse(e, 1);
		e = '0;
		e.rxPush = 1'b1;
		repeat (m) pulse(e, 1);
		e = '0;
		e.rxPop = 1'b1;
		pulse(e, 1);
		xfer(1'b1, TX_FIFO_LEVEL_ADDR, 32'h0000_003F);
		rd(TX_FIFO_LEVEL_ADDR, k, 1'b0);
		rd(RX_FIFO_LEVEL_ADDR, m - 1, 1'b0);
		rd(BUS_STATUS_ADDR, 32'h0000_000A, 1'b0);
		cfg.ctrlEnable <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("flush", 32'h0000_0001, {31'h0, flush});
		cfg.ctrlEnable <= 1'b1;
		rd(TX_FIFO_LEVEL_ADDR, 32'h0000_0000, 1'b0);
		rd(RX_FIFO_LEVEL_ADDR, 32'h0000_0000, 1'b0);
		$display("test levels done");
		e = '0;
		e.startByteAcked = 1'b1;
		pulse(e, 1);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		xfer(1'b1, IRQ_MASK_ADDR, 32'h0000_0001);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		xfer(1'b1, IRQ_STATUS_ADDR, 32'h0000_0001);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		e = '0;
		e.txPush = 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			if (i == 2)
				pulse(e, 1);
			cause(i);
		end
		final_report();
	end
endmodule
`default_nettype wire
